// File: rtl/crb_capture_record_builder.sv
// Functional notes
// [RL1] software keeps snap length within 32..2044
// [RL2] snap length rounded down to four bytes
// [RL3] variable mode truncates long packets to snap
// [RL4] variable mode short packets give short records
// [RL5] fixed mode cuts or pads to snap
// [RL6] sixteen byte header, content, alignment pad
// [RL7] one record written per received packet; code also drops a packet that starts while a record is still being emitted
// [RL8] host reader drains faster than arrival
// [RL9] drop arriving packets while host buffer full
// [RL10] loss counter carried in record header
// [RL11] capture indicator dark while buffer full
// [RL12] host provides capture buffer below limit
// [RL13] default is fixed mode, snap 48
// [RL14] config changes only at packet boundary
// [RL15] loss counter saturates, cleared per record
`timescale 1ns/1ps
module crb_capture_record_builder
  import crb_pkg::*;
(
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // configuration
  input  wire logic        i_cfg_load,
  input  wire logic        i_cfg_default,
  input  wire crb_cfg_t    i_cfg,
  // received packet words
  input  wire logic        i_rx_valid,
  input  wire logic [31:0] i_rx_data,
  input  wire logic        i_rx_last,
  input  wire logic [2:0]  i_rx_bytes,
  // host buffer record stream
  input  wire logic        i_host_full,
  input  wire logic        i_rec_ready,
  output crb_word_t        o_rec,
  output logic             o_rec_valid,
  // indicator
  output logic             o_capture_led
);
  crb_cfg_t    cfg_q;
  crb_cfg_t    pkt_cfg_q;
  crb_rx_st_t  rx_q;
  crb_em_st_t  em_q;
  logic [31:0] mem_q [CRB_MEM_WORDS];
  logic [8:0]  wr_idx_q;
  logic [15:0] wire_len_q;
  logic [15:0] loss_q;
  logic [8:0]  stored_q;
  logic [9:0]  body_q;
  logic [9:0]  idx_q;
  logic [15:0] hdr_len_q;
  logic [15:0] hdr_wire_q;
  logic        trunc_q;
  crb_word_t   skid_q;
  logic        skid_v_q;
  logic        fifo_rdy;
  logic        push;
  crb_word_t   push_w;
  logic        pop;
  logic        pkt_start;
  logic        accept;
  logic        rx_end;
  logic        drop;
  logic [8:0]  snap_w;
  logic [8:0]  cap_w;
  logic [8:0]  cont_w;
  logic [9:0]  pad_w;
  logic [15:0] len_now;
  crb_cfg_t    use_cfg;

  // active configuration; reset and default both give fixed mode, 48 bytes
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cfg_q <= '{varlen: CRB_VARLEN_DEFAULT, slen: CRB_SLEN_DEFAULT};
    end else if (i_cfg_default) begin
      cfg_q <= '{varlen: CRB_VARLEN_DEFAULT, slen: CRB_SLEN_DEFAULT}; // RL13
    end else if (i_cfg_load) begin
      cfg_q <= i_cfg;
    end
  end

  assign pkt_start = i_rx_valid && (rx_q == CRB_R_IDLE);
  // a packet already owning the word store also blocks a new one
  assign accept    = pkt_start && !i_host_full && (em_q == CRB_E_IDLE); // RL9
  assign drop      = pkt_start && !accept;
  assign rx_end    = i_rx_valid && i_rx_last && (accept || rx_q == CRB_R_CAP);
  // the snapshot lags the first word by one edge, so that word uses the live config
  assign use_cfg   = accept ? cfg_q : pkt_cfg_q; // RL14
  assign snap_w    = use_cfg.slen[10:2]; // RL2
  assign len_now   = wire_len_q + 16'(i_rx_bytes);
  // words actually captured, bounded by snap length
  assign cap_w     = (wr_idx_q < snap_w || accept) ? wr_idx_q + 9'd1 : wr_idx_q;
  assign cont_w    = use_cfg.varlen ? cap_w : snap_w; // RL3 RL4 RL5
  assign pad_w     = {1'b0, cont_w} + {9'd0, cont_w[0]}; // RL6

  // receive state: config snapshot taken at each accepted packet start
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_q      <= CRB_R_IDLE;
      pkt_cfg_q <= '{varlen: CRB_VARLEN_DEFAULT, slen: CRB_SLEN_DEFAULT};
    end else begin
      if (accept) begin
        pkt_cfg_q <= cfg_q; // RL14
      end
      if (i_rx_valid && i_rx_last) begin
        rx_q <= CRB_R_IDLE;
      end else if (pkt_start) begin
        rx_q <= accept ? CRB_R_CAP : CRB_R_DROP; // RL9
      end
    end
  end

  // word store and length count
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_idx_q   <= 9'd0;
      wire_len_q <= 16'd0;
    end else if (rx_end) begin
      wr_idx_q   <= 9'd0;
      wire_len_q <= 16'd0;
    end else if (i_rx_valid && (accept || rx_q == CRB_R_CAP)) begin
      wire_len_q <= wire_len_q + 16'(CRB_WORD_BYTES);
      if (wr_idx_q < (accept ? cfg_q.slen[10:2] : snap_w)) begin
        wr_idx_q <= wr_idx_q + 9'd1; // RL3
      end
    end
  end

  // the array has no reset, it is only read below the stored count
  always_ff @(posedge i_clk) begin
    if (i_rx_valid && (accept || rx_q == CRB_R_CAP) && wr_idx_q < snap_w) begin
      mem_q[wr_idx_q] <= i_rx_data;
    end
  end

  // loss counter: a drop in the header cycle still counts, the set wins
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      loss_q <= 16'd0;
    end else if (em_q == CRB_E_HDR && idx_q == 10'd0 && push) begin
      loss_q <= drop ? 16'd1 : 16'd0; // RL15
    end else if (drop && loss_q != CRB_LOSS_MAX) begin
      loss_q <= loss_q + 16'd1; // RL15
    end
  end

  // record emitter: header words, then body words with zero padding
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      em_q       <= CRB_E_IDLE;
      idx_q      <= 10'd0;
      body_q     <= 10'd0;
      stored_q   <= 9'd0;
      hdr_len_q  <= 16'd0;
      hdr_wire_q <= 16'd0;
      trunc_q    <= 1'b0;
    end else begin
      case (em_q)
        CRB_E_IDLE: begin
          if (rx_end) begin
            em_q       <= CRB_E_HDR; // RL7
            idx_q      <= 10'd0;
            body_q     <= pad_w;
            stored_q   <= (cap_w < cont_w) ? cap_w : cont_w;
            hdr_len_q  <= 16'(CRB_HDR_BYTES) + {4'd0, pad_w, 2'b00}; // RL6
            hdr_wire_q <= len_now;
            trunc_q    <= len_now > {5'd0, snap_w, 2'b00};
          end
        end
        CRB_E_HDR: begin
          if (push) begin
            if (idx_q == 10'(CRB_HDR_WORDS - 3'd1)) begin
              em_q  <= CRB_E_BODY;
              idx_q <= 10'd0;
            end else begin
              idx_q <= idx_q + 10'd1;
            end
          end
        end
        CRB_E_BODY: begin
          if (push) begin
            if (idx_q == body_q - 10'd1) begin
              em_q <= CRB_E_IDLE;
            end
            idx_q <= idx_q + 10'd1;
          end
        end
        default: em_q <= CRB_E_IDLE;
      endcase
    end
  end

  always_comb begin
    push_w = '{data: 32'h0, last: 1'b0};
    push   = fifo_rdy && (em_q == CRB_E_HDR || em_q == CRB_E_BODY);
    if (em_q == CRB_E_HDR) begin
      case (idx_q[1:0])
        2'd0:    push_w.data = {loss_q, hdr_len_q}; // RL10
        2'd1:    push_w.data = {16'h0, hdr_wire_q};
        2'd2:    push_w.data = {30'h0, trunc_q, pkt_cfg_q.varlen};
        default: push_w.data = 32'h0;
      endcase
    end else if (em_q == CRB_E_BODY) begin
      // words past the captured data are padding, sent as zero
      push_w.data = (idx_q < {1'b0, stored_q}) ? mem_q[idx_q[8:0]] : 32'h0; // RL5
      push_w.last = (idx_q == body_q - 10'd1);
    end
  end

  // two-entry buffer toward the host: output register plus one skid word
  assign fifo_rdy = !skid_v_q;
  assign pop      = o_rec_valid && i_rec_ready;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rec       <= '{data: 32'h0, last: 1'b0};
      o_rec_valid <= 1'b0;
      skid_q      <= '{data: 32'h0, last: 1'b0};
      skid_v_q    <= 1'b0;
    end else if (pop || !o_rec_valid) begin
      if (skid_v_q) begin
        o_rec    <= skid_q;
        skid_v_q <= 1'b0;
      end else begin
        o_rec       <= push_w;
        o_rec_valid <= push;
      end
    end else if (push) begin
      skid_q   <= push_w;
      skid_v_q <= 1'b1;
    end
  end

  // indicator goes dark while the host buffer is full
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_capture_led <= 1'b0;
    end else begin
      o_capture_led <= !i_host_full; // RL11
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  a_hdr_aligned: assert property ( // RL6
    (em_q == CRB_E_HDR && push && idx_q == 10'd0) |->
      (push_w.data[2:0] == 3'd0 && push_w.data[15:0] >= 16'd16))
    else $error("record length not aligned or below header size");
  a_fixed_len: assert property ( // RL5
    (em_q == CRB_E_HDR && !pkt_cfg_q.varlen) |->
      hdr_len_q == 16'(CRB_HDR_BYTES) + {4'd0, {1'b0, snap_w} + {9'd0, snap_w[0]}, 2'b00})
    else $error("fixed record length differs from snap length");
  a_var_bound: assert property ( // RL3
    (em_q == CRB_E_HDR && pkt_cfg_q.varlen) |->
      hdr_len_q <= 16'(CRB_HDR_BYTES) + {4'd0, {1'b0, snap_w} + {9'd0, snap_w[0]}, 2'b00})
    else $error("variable record longer than snap length");
  a_var_short: assert property ( // RL4
    (em_q == CRB_E_HDR && pkt_cfg_q.varlen) |->
      hdr_len_q <= 16'(CRB_HDR_BYTES) + ((hdr_wire_q + 16'd11) & 16'hfff8))
    else $error("short packet record padded too far");
  a_drop_full: assert property ( // RL9
    (pkt_start && i_host_full && !i_rx_last) |=> rx_q == CRB_R_DROP)
    else $error("packet accepted while host buffer full");
  a_led_dark: assert property ( // RL11
    i_host_full |=> !o_capture_led)
    else $error("indicator lit while host buffer full");
  a_loss_sat: assert property ( // RL15
    (loss_q == CRB_LOSS_MAX && em_q != CRB_E_HDR) |=> loss_q == CRB_LOSS_MAX)
    else $error("loss counter wrapped");
  a_loss_field: assert property ( // RL10
    (em_q == CRB_E_HDR && push && idx_q == 10'd0) |-> push_w.data[31:16] == loss_q)
    else $error("loss counter missing from header");
  a_cfg_frozen: assert property ( // RL14
    (em_q != CRB_E_IDLE) |=> $stable(pkt_cfg_q))
    else $error("capture config changed inside a packet");
  a_one_record: assert property ( // RL7
    (rx_end && em_q == CRB_E_IDLE) |=> em_q == CRB_E_HDR ##[1:8] push)
    else $error("captured packet produced no record");
  a_cfg_default: assert property ( // RL13
    i_cfg_default |=> (!cfg_q.varlen && cfg_q.slen == CRB_SLEN_DEFAULT))
    else $error("default config not fixed mode snap 48");
  a_out_hold: assert property (
    (o_rec_valid && !i_rec_ready) |=> (o_rec_valid && $stable(o_rec)))
    else $error("record word changed while stalled");

  c_var_record: cover property (em_q == CRB_E_HDR && pkt_cfg_q.varlen && push);
  c_fixed_pad:  cover property (em_q == CRB_E_BODY && push && idx_q >= {1'b0, stored_q});
  c_drop_full:  cover property (drop && i_host_full);
  c_stall:      cover property (skid_v_q && !i_rec_ready);
endmodule // crb_capture_record_builder

// File: rtl/crb_pkg.sv
package crb_pkg;
  // snap length limits and defaults, in bytes
  localparam logic [10:0] CRB_SLEN_MIN     = 11'd32;
  localparam logic [10:0] CRB_SLEN_MAX     = 11'd2044;
  localparam logic [10:0] CRB_SLEN_DEFAULT = 11'd48;
  localparam logic        CRB_VARLEN_DEFAULT = 1'b0;
  // record layout
  localparam int          CRB_HDR_BYTES    = 16;
  localparam logic [2:0]  CRB_HDR_WORDS    = 3'd4;
  localparam int          CRB_MEM_WORDS    = 512;
  localparam logic [15:0] CRB_LOSS_MAX     = 16'hffff;
  localparam logic [2:0]  CRB_WORD_BYTES   = 3'd4;
  // header word 2 flag positions
  localparam int          CRB_FLAG_VARLEN  = 0;
  localparam int          CRB_FLAG_TRUNC   = 1;

  typedef struct packed {
    logic [31:0] data;
    logic        last;
  } crb_word_t;

  typedef struct packed {
    logic        varlen;
    logic [10:0] slen;
  } crb_cfg_t;

  typedef enum logic [1:0] {
    CRB_R_IDLE = 2'b00,
    CRB_R_CAP  = 2'b01,
    CRB_R_DROP = 2'b10
  } crb_rx_st_t;

  typedef enum logic [1:0] {
    CRB_E_IDLE = 2'b00,
    CRB_E_HDR  = 2'b01,
    CRB_E_BODY = 2'b10
  } crb_em_st_t;
endpackage

// File: verification/crb_host_model.sv
`timescale 1ns/1ps
module crb_host_model
  import crb_pkg::*;
(
  // clock and reset
  input  wire logic      i_clk,
  input  wire logic      i_rst_n,
  // record stream from the builder, and the slow mode select from the testbench
  input  wire crb_word_t i_rec,
  input  wire logic      i_rec_valid,
  input  wire logic      i_slow,
  output logic           o_rec_ready
);
  // the queue stands in for the host capture buffer; runs here stay far below its size
  logic [31:0] q[$];
  logic        lq[$];
  int          n_rec;
  logic [1:0]  cnt_q;

  // slow mode takes one word in four, still quicker than records arrive
  assign o_rec_ready = !i_slow || (cnt_q == 2'h3);

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q <= 2'h0;
      n_rec <= 0;
    end else begin
      cnt_q <= cnt_q + 2'h1;
      if (i_rec_valid && o_rec_ready) begin
        q.push_back(i_rec.data);
        lq.push_back(i_rec.last);
        if (i_rec.last) begin
          n_rec <= n_rec + 1;
        end
      end
    end
  end
endmodule // crb_host_model

// File: verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import crb_pkg::*;
  // last field: record length in bytes that the row should give
  typedef struct {bit v; int sl; int nw; int lb; int rl;} crb_row_t;
  logic        clk, rst_n, cfg_load, cfg_default, rx_valid, rx_last;
  logic        host_full, rec_ready, rec_valid, led, slow;
  logic [31:0] rx_data;
  logic [31:0] hdr_w0;
  logic [2:0]  rx_bytes;
  crb_cfg_t    cfg;
  crb_word_t   rec;
  int          err_count, n_checks, r_seen;
  crb_row_t    rows[6] = '{'{0, 44, 2, 3, 64}, '{0, 48, 20, 4, 64}, '{1, 48, 1, 4, 24},
                           '{1, 47, 30, 2, 64}, '{1, 32, 3, 1, 32}, '{1, 2044, 40, 4, 176}};

  crb_capture_record_builder crb_capture_record_builder_i (.i_clk(clk), .i_rst_n(rst_n),
    .i_cfg_load(cfg_load), .i_cfg_default(cfg_default), .i_cfg(cfg), .i_rx_valid(rx_valid),
    .i_rx_data(rx_data), .i_rx_last(rx_last), .i_rx_bytes(rx_bytes), .i_host_full(host_full),
    .i_rec_ready(rec_ready), .o_rec(rec), .o_rec_valid(rec_valid), .o_capture_led(led));
  crb_host_model crb_host_model_i (.i_clk(clk), .i_rst_n(rst_n), .i_rec(rec),
    .i_rec_valid(rec_valid), .i_slow(slow), .o_rec_ready(rec_ready));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic results;
    if (err_count == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // cw picks the word during which a new config is loaded, -1 for none
  task automatic send(input int nw, input int lb, input int cw, input crb_cfg_t nc);
    for (int k = 0; k < nw; k++) begin
      @(negedge clk);
      rx_valid = 1'b1;
      rx_data  = 32'ha5000000 | k;
      rx_last  = (k == nw - 1);
      rx_bytes = lb[2:0];
      cfg_load = (k == cw);
      if (k == cw) cfg = nc;
    end
    @(negedge clk);
    rx_valid = 1'b0;
    rx_last  = 1'b0;
    cfg_load = 1'b0;
  endtask

  task automatic load(input bit v, input int sl);
    @(negedge clk);
    cfg      = '{v, sl[10:0]};
    cfg_load = 1'b1;
    @(negedge clk);
    cfg_load = 1'b0;
  endtask

  task automatic expect_rec(input bit v, input int sl, input int nw, input int lb,
                            input int loss);
    int i, wl, sw, cw, bw;
    for (i = 0; i < 3000 && crb_host_model_i.n_rec <= r_seen; i++) @(negedge clk);
    if (i == 3000) begin
      err_count++;
      results();
    end
    r_seen++;
    wl = 4 * (nw - 1) + lb;
    sw = sl / 4;
    cw = v ? (((wl + 3) / 4 < sw) ? (wl + 3) / 4 : sw) : sw;
    bw = cw + cw % 2;
    chk_word(32'(crb_host_model_i.q.size()), 32'(bw + 4));
    if (crb_host_model_i.q.size() == bw + 4) begin
      chk_word(crb_host_model_i.q[0], {loss[15:0], 16'(16 + 4 * bw)});
      chk_word(crb_host_model_i.q[1], 32'(wl));
      chk_word(crb_host_model_i.q[2], {30'h0, wl > sw * 4, v});
      chk_word(crb_host_model_i.q[3], 32'h0);
      for (i = 0; i < bw; i++)
        chk_word(crb_host_model_i.q[4 + i], (i < cw && i < nw) ? 32'ha5000000 | i : 32'h0);
      chk_word({31'h0, crb_host_model_i.lq[bw + 3]}, 32'h1);
    end
    hdr_w0 = crb_host_model_i.q[0];
    crb_host_model_i.q.delete();
    crb_host_model_i.lq.delete();
  endtask

  initial begin
    {rst_n, cfg_load, cfg_default, rx_valid, rx_last, host_full, slow} = 7'h0;
    {rx_data, rx_bytes} = 35'h0;
    cfg = '{1'b0, 11'h0};
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    chk_word({31'h0, led}, 32'h1);
    send(5, 4, -1, cfg);
    expect_rec(0, 48, 5, 4, 0);
    foreach (rows[r]) begin
      load(rows[r].v, rows[r].sl);
      send(rows[r].nw, rows[r].lb, -1, cfg);
      expect_rec(rows[r].v, rows[r].sl, rows[r].nw, rows[r].lb, 0);
      chk_word({16'h0, hdr_w0[15:0]}, 32'(rows[r].rl));
    end
    // receiver stalls from here on
    slow = 1'b1;
    send(4, 4, 1, '{1'b1, 11'd32});
    expect_rec(1, 2044, 4, 4, 0);
    send(3, 4, -1, cfg);
    expect_rec(1, 32, 3, 4, 0);
    @(negedge clk);
    cfg_default = 1'b1;
    @(negedge clk);
    cfg_default = 1'b0;
    send(2, 4, -1, cfg);
    expect_rec(0, 48, 2, 4, 0);
    host_full = 1'b1;
    @(negedge clk);
    chk_word({31'h0, led}, 32'h0);
    send(1, 4, -1, cfg);
    send(2, 4, -1, cfg);
    repeat (20) @(negedge clk);
    chk_word(32'(crb_host_model_i.n_rec), 32'(r_seen));
    host_full = 1'b0;
    repeat (2) @(negedge clk);
    chk_word({31'h0, led}, 32'h1);
    send(2, 4, -1, cfg);
    expect_rec(0, 48, 2, 4, 2);
    load(1, 32);
    rst_n = 1'b0;
    @(negedge clk);
    chk_word({30'h0, rec_valid, led}, 32'h0);
    rst_n = 1'b1;
    r_seen = 0;
    send(1, 4, -1, cfg);
    expect_rec(0, 48, 1, 4, 0);
    results();
  end
endmodule // tb_top
